// >>> core/dpram_pkg.sv
// Constants and carrier types for the dual-port coprocessor RAM
package dpram_pkg;
    // ==========================================================
    // Array geometry
    localparam int RAM_BYTES = 8192;          // Total array size in bytes
    localparam int WORD_W = 16;               // Data word width
    localparam int ADDR_W = 12;               // Word address width (8 Kbytes of 16-bit words)
    localparam logic [ADDR_W-1:0] LAST_WORD = 12'hFFF; // Highest word address
    // ==========================================================
    // System bus decode
    localparam int BUS_ADDR_W = 24;           // Byte address width on the module bus
    localparam int BASE_W = 16;               // Base address register width
    localparam int DECODE_LO = 13;            // Lowest bus address bit compared with the base
    localparam int BASE_LO = 5;               // Base bit aligned with DECODE_LO
    localparam int WORD_LO = 1;               // Lowest bus address bit of the word index
    localparam logic [BASE_W-1:0] BASE_RESET = 16'hFFA0; // Expected base value
    // ==========================================================
    // Signature calculator
    localparam int SIG_W = 32;                // Signature width
    localparam logic [SIG_W-1:0] SIG_SEED = 32'hFFFFFFFF; // Start value
    localparam logic [SIG_W-1:0] SIG_POLY = 32'h80200003; // Feedback taps
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic req;                            // Access request, one cycle
        logic we;                             // Write when high
        logic fetch;                          // Instruction fetch attempt
        logic [BUS_ADDR_W-1:0] addr;          // Byte address
        logic [WORD_W-1:0] wdata;             // Write data
    } sys_req_t;
    typedef struct packed {
        logic req;                            // Microcode read request, one cycle
        logic [ADDR_W-1:0] addr;              // Word address
    } cop_req_t;
    typedef enum logic [1:0] {
        MISC_IDLE,
        MISC_ISSUE,
        MISC_FOLD
    } misc_state_t;
endpackage : dpram_pkg

// >>> core/coproc_ram_array.sv
// Two-port static array with registered read data
`timescale 1ns/1ps
module coproc_ram_array #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic p0_en,
    input wire logic p0_we,
    input wire logic [AW-1:0] p0_addr,
    input wire logic [DW-1:0] p0_wdata,
    output logic [DW-1:0] p0_rdata_q,
    input wire logic p1_en,
    input wire logic [AW-1:0] p1_addr,
    output logic [DW-1:0] p1_rdata_q
);
    // ==========================================================
    // Storage
    logic [DW-1:0] mem [0:(1<<AW)-1];         // Array cells, no reset
    logic [DW-1:0] p0_rdata_d;                // Next read word, port 0
    logic [DW-1:0] p1_rdata_d;                // Next read word, port 1

    // Read data next values, hold when idle
    always_comb begin
        p0_rdata_d = p0_rdata_q;
        p1_rdata_d = p1_rdata_q;
        if (p0_en && !p0_we) begin
            p0_rdata_d = mem[p0_addr];
        end
        if (p1_en) begin
            p1_rdata_d = mem[p1_addr];
        end
    end

    // Array write, no reset on contents
    always_ff @(posedge ref_clk) begin
        if (p0_en && p0_we) begin
            mem[p0_addr] <= p0_wdata;
        end
    end

    // Read registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            p0_rdata_q <= '0;
            p1_rdata_q <= '0;
        end else begin
            p0_rdata_q <= p0_rdata_d;
            p1_rdata_q <= p1_rdata_d;
        end
    end
endmodule : coproc_ram_array

// >>> core/dual_port_coproc_ram.sv
// Dual-port coprocessor RAM: bus port, two microcode ports, stop and signature
`timescale 1ns/1ps
module dual_port_coproc_ram
    import dpram_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = WORD_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [BASE_W-1:0] array_base_address,
    input wire logic stop_req,
    input wire logic emu_a,
    input wire logic emu_b,
    input wire sys_req_t bus_req,
    output logic bus_ack_q,
    output logic bus_err_q,
    output logic [DW-1:0] bus_rdata,
    input wire cop_req_t cop_a_req,
    output logic cop_a_valid_q,
    output logic [DW-1:0] cop_a_rdata,
    input wire cop_req_t cop_b_req,
    output logic cop_b_valid_q,
    output logic [DW-1:0] cop_b_rdata,
    input wire logic misc_start,
    output logic misc_busy_q,
    output logic misc_done_q,
    output logic [SIG_W-1:0] misc_sig_q,
    output logic low_power_q
);
    // ==========================================================
    // Mode and decode
    logic microcode;                          // Either coprocessor emulates
    logic bus_hit;                            // Bus address inside the array window
    logic bus_ok;                             // Bus access granted to the array
    logic bus_refuse;                         // Bus access answered with error
    logic [AW-1:0] bus_word;                  // Word index from bus address

    assign microcode = emu_a | emu_b;
    // Array window follows the base register
    assign bus_hit = bus_req.req &&
        (bus_req.addr[BUS_ADDR_W-1:DECODE_LO] == array_base_address[BASE_W-1:BASE_LO]);
    // Refuse during microcode mode, stop or instruction fetch
    assign bus_refuse = bus_hit && (microcode || low_power_q || bus_req.fetch);
    assign bus_ok = bus_hit && !bus_refuse;
    assign bus_word = bus_req.addr[WORD_LO+AW-1:WORD_LO];

    // ==========================================================
    // Array port steering
    logic p0_en;                              // Port 0 enable
    logic p0_we;                              // Port 0 write
    logic [AW-1:0] p0_addr;                   // Port 0 address
    logic p1_en;                              // Port 1 enable
    logic [AW-1:0] p1_addr;                   // Port 1 address
    logic misc_rd;                            // Signature walk read this cycle
    logic [AW-1:0] misc_addr_q;               // Word being read by the walk
    logic [DW-1:0] p0_rdata;                  // Registered read word, port 0
    logic [DW-1:0] p1_rdata;                  // Registered read word, port 1

    // Port 0: bus outside microcode mode, coprocessor A while it emulates
    always_comb begin
        p0_en = 1'b0;
        p0_we = 1'b0;
        p0_addr = bus_word;
        if (emu_a) begin
            p0_en = cop_a_req.req;
            p0_addr = cop_a_req.addr;
        end else if (bus_ok) begin
            p0_en = 1'b1;
            p0_we = bus_req.we;
        end
    end

    // Port 1: coprocessor B in emulation, else signature walk
    always_comb begin
        p1_en = 1'b0;
        p1_addr = misc_addr_q;
        if (emu_b) begin
            p1_en = cop_b_req.req;
            p1_addr = cop_b_req.addr;
        end else if (misc_rd) begin
            p1_en = 1'b1;
        end
    end

    // Single array shared by all ports
    coproc_ram_array #(
        .AW(AW),
        .DW(DW)
    ) u_array (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .p0_en(p0_en),
        .p0_we(p0_we),
        .p0_addr(p0_addr),
        .p0_wdata(bus_req.wdata),
        .p0_rdata_q(p0_rdata),
        .p1_en(p1_en),
        .p1_addr(p1_addr),
        .p1_rdata_q(p1_rdata)
    );

    assign bus_rdata = p0_rdata;
    assign cop_a_rdata = p0_rdata;
    assign cop_b_rdata = p1_rdata;

    // ==========================================================
    // Answers and stop state
    logic bus_ack_d;                          // Next bus acknowledge
    logic bus_err_d;                          // Next bus error
    logic cop_a_valid_d;                      // Next coprocessor A valid
    logic cop_b_valid_d;                      // Next coprocessor B valid
    logic low_power_d;                        // Next stop state

    // Next answers, one cycle after the request
    always_comb begin
        bus_ack_d = bus_hit;
        bus_err_d = bus_refuse;
        cop_a_valid_d = emu_a && cop_a_req.req;
        cop_b_valid_d = emu_b && cop_b_req.req;
        low_power_d = stop_req && !microcode;
    end

    // Answer and stop registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_ack_q <= 1'b0;
            bus_err_q <= 1'b0;
            cop_a_valid_q <= 1'b0;
            cop_b_valid_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            bus_ack_q <= bus_ack_d;
            bus_err_q <= bus_err_d;
            cop_a_valid_q <= cop_a_valid_d;
            cop_b_valid_q <= cop_b_valid_d;
            low_power_q <= low_power_d;
        end
    end

    // ==========================================================
    // Signature calculator
    misc_state_t misc_st_q;                   // Walk state
    misc_state_t misc_st_d;
    logic [AW-1:0] misc_addr_d;               // Next word to read
    logic [SIG_W-1:0] misc_sig_d;
    logic misc_busy_d;
    logic misc_done_d;
    logic [SIG_W-1:0] sig_shift;              // Shifted signature with feedback

    assign misc_rd = (misc_st_q == MISC_ISSUE) && !emu_b && !low_power_q;

    // Walk every word, fold read data into the signature
    always_comb begin
        misc_st_d = misc_st_q;
        misc_addr_d = misc_addr_q;
        misc_sig_d = misc_sig_q;
        misc_done_d = 1'b0;
        sig_shift = {misc_sig_q[SIG_W-2:0], 1'b0} ^ (misc_sig_q[SIG_W-1] ? SIG_POLY : '0);
        case (misc_st_q)
            MISC_IDLE: begin
                if (misc_start) begin
                    misc_st_d = MISC_ISSUE;
                    misc_addr_d = '0;
                    misc_sig_d = SIG_SEED;
                end
            end
            MISC_ISSUE: begin
                // Waits while port 1 serves coprocessor B or stop holds
                if (misc_rd) begin
                    misc_st_d = MISC_FOLD;
                end
            end
            MISC_FOLD: begin
                misc_sig_d = sig_shift ^ {{(SIG_W-DW){1'b0}}, p1_rdata};
                if (misc_addr_q == LAST_WORD) begin
                    misc_st_d = MISC_IDLE;
                    misc_done_d = 1'b1;
                end else begin
                    misc_st_d = MISC_ISSUE;
                    misc_addr_d = misc_addr_q + AW'(1);
                end
            end
            default: begin
                misc_st_d = MISC_IDLE;
            end
        endcase
        misc_busy_d = (misc_st_d != MISC_IDLE);
    end

    // Signature registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            misc_st_q <= MISC_IDLE;
            misc_addr_q <= '0;
            misc_sig_q <= SIG_SEED;
            misc_busy_q <= 1'b0;
            misc_done_q <= 1'b0;
        end else begin
            misc_st_q <= misc_st_d;
            misc_addr_q <= misc_addr_d;
            misc_sig_q <= misc_sig_d;
            misc_busy_q <= misc_busy_d;
            misc_done_q <= misc_done_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_bus_refused_emu: assert property (bus_hit && microcode |=> bus_ack_q && bus_err_q)
        else $error("bus access in microcode mode not refused");
    a_bus_grant_ok: assert property (bus_hit && !microcode && !low_power_q && !bus_req.fetch
        |=> bus_ack_q && !bus_err_q)
        else $error("bus access not granted outside emulation");
    a_no_write_emu: assert property (p0_we |-> !microcode && bus_hit)
        else $error("array written while bus refused");
    a_fetch_refused: assert property (bus_hit && bus_req.fetch |=> bus_err_q)
        else $error("instruction fetch not refused");
    a_stop_blocked: assert property (microcode |=> !low_power_q)
        else $error("stop entered during emulation");
    a_stop_enter: assert property (stop_req && !microcode |=> low_power_q)
        else $error("stop not entered");
    a_both_cop_read: assert property (emu_a && emu_b && cop_a_req.req && cop_b_req.req
        |=> cop_a_valid_q && cop_b_valid_q)
        else $error("simultaneous coprocessor reads blocked");
    a_bus_readback: assert property (bus_ok && bus_req.we ##1 bus_ok && !bus_req.we
        && $past(bus_word) == bus_word |=> bus_rdata == $past(bus_req.wdata, 2))
        else $error("bus read did not return written word");
    a_misc_done: assert property (misc_done_q |-> $past(misc_st_q) == MISC_FOLD
        && $past(misc_addr_q) == LAST_WORD && !misc_busy_q)
        else $error("signature done without full walk");
    a_misc_fold: assert property (misc_st_q == MISC_FOLD |=> misc_sig_q ==
        ($past(sig_shift) ^ {{(SIG_W-DW){1'b0}}, $past(p1_rdata)}))
        else $error("signature fold wrong");

    c_bus_write: cover property (bus_ok && bus_req.we);
    c_dual_emu: cover property (cop_a_valid_q && cop_b_valid_q);
    c_stop_held: cover property (stop_req && microcode ##1 stop_req && !microcode ##1 low_power_q);
    c_misc_done: cover property (misc_done_q);
endmodule : dual_port_coproc_ram

// >>> tb/cop_model.sv
// Coprocessor model: emulation flag and microcode read stream
`timescale 1ns/1ps
module cop_model
    import dpram_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic hold,
    input wire logic [ADDR_W-1:0] first_addr,
    output logic emu,
    output cop_req_t req
);
    // ==========================================================
    // Request stream
    logic [ADDR_W-1:0] cnt; // Next word to fetch
    initial begin
        emu = 1'b0;
        req = '0;
        cnt = '0;
    end
    // Emulation goes up first, reads follow while it stays up
    always @(negedge ref_clk) begin
        emu <= run & ~sys_rst;
        if (run && emu && !hold && !sys_rst) begin
            req.req <= 1'b1;
            req.addr <= cnt;
            cnt <= cnt + 12'h001;
        end else begin
            // Idle address lines wander, never keep the last value
            req.req <= 1'b0;
            req.addr <= ~req.addr;
            if (!run) begin
                cnt <= first_addr;
            end
        end
    end
endmodule : cop_model

// >>> tb/dual_port_coproc_ram_tb.sv
// Self-checking testbench for the dual-port coprocessor RAM
`timescale 1ns/1ps
module dual_port_coproc_ram_tb import dpram_pkg::*; ();
    // ==========================================================
    // Stimulus and observed signals
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [BASE_W-1:0] array_base_address = BASE_RESET;
    logic stop_req = 1'b0;
    logic misc_start = 1'b0;
    logic run_a = 1'b0, run_b = 1'b0, hold_b = 1'b0;
    sys_req_t bus_req = '0;
    cop_req_t cop_a_req, cop_b_req, pa = '0, pb = '0;
    logic emu_a, emu_b, bus_ack_q, bus_err_q, cop_a_valid_q, cop_b_valid_q;
    logic misc_busy_q, misc_done_q, low_power_q;
    logic [WORD_W-1:0] bus_rdata, cop_a_rdata, cop_b_rdata, last_rd = '0;
    logic [SIG_W-1:0] misc_sig_q;
    logic [WORD_W-1:0] mem [0:4095]; // Expected array contents
    int n_fail = 0;
    int checks_done = 0;
    always #50 ref_clk = ~ref_clk;
    dual_port_coproc_ram dual_port_coproc_ram_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .array_base_address(array_base_address), .stop_req(stop_req), .emu_a(emu_a), .emu_b(emu_b),
        .bus_req(bus_req), .bus_ack_q(bus_ack_q), .bus_err_q(bus_err_q), .bus_rdata(bus_rdata),
        .cop_a_req(cop_a_req), .cop_a_valid_q(cop_a_valid_q), .cop_a_rdata(cop_a_rdata),
        .cop_b_req(cop_b_req), .cop_b_valid_q(cop_b_valid_q), .cop_b_rdata(cop_b_rdata),
        .misc_start(misc_start), .misc_busy_q(misc_busy_q), .misc_done_q(misc_done_q),
        .misc_sig_q(misc_sig_q), .low_power_q(low_power_q));
    cop_model cop_model_a_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .run(run_a), .hold(1'b0),
        .first_addr(12'h000), .emu(emu_a), .req(cop_a_req));
    cop_model cop_model_b_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .run(run_b), .hold(hold_b),
        .first_addr(12'hFF8), .emu(emu_b), .req(cop_b_req));
    // ==========================================================
    // Reporting
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Coprocessor answer monitor
    always @(posedge ref_clk) begin
        pa <= cop_a_req;
        pb <= cop_b_req;
    end
    // Every taken read answers one cycle later with the stored word
    always @(negedge ref_clk) begin
        if (!sys_rst) begin
            check(cop_a_valid_q, pa.req, "cop a valid");
            check(cop_b_valid_q, pb.req, "cop b valid");
            if (pa.req) check(cop_a_rdata, mem[pa.addr], "cop a data");
            if (pb.req) check(cop_b_rdata, mem[pb.addr], "cop b data");
        end
    end
    // ==========================================================
    // Bus helpers
    function automatic logic [23:0] wa(input logic [11:0] w);
        return {BASE_RESET[15:5], w, 1'b0};
    endfunction : wa
    // One access, answer judged in the following cycle
    task automatic bus_op(input logic we, input logic fetch, input logic [23:0] addr,
                          input logic [15:0] wd, input logic hit, input logic err);
        @(negedge ref_clk);
        bus_req <= '{req: 1'b1, we: we, fetch: fetch, addr: addr, wdata: wd};
        @(negedge ref_clk);
        bus_req <= '{req: 1'b0, we: ~we, fetch: 1'b0, addr: ~addr, wdata: ~wd};
        if (hit && !err && we) mem[addr[12:1]] = wd;
        if (hit && !err && !we) last_rd = mem[addr[12:1]];
        check(bus_ack_q, hit, "bus ack");
        check(bus_err_q, hit & err, "bus error");
        check(bus_rdata, last_rd, "bus read data");
    endtask : bus_op
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        check(low_power_q, 1'b0, "stop after reset");
        check(misc_sig_q, SIG_SEED, "signature after reset");
        check({bus_ack_q, misc_busy_q, misc_done_q}, 3'b000, "pulses after reset");
    endtask : t_reset
    // Back-to-back writes over the whole array, odd byte address bit set
    task automatic fill_all;
        for (int i = 0; i <= 4096; i++) begin
            @(negedge ref_clk);
            if (i > 0) check({bus_ack_q, bus_err_q}, 2'b10, "fill answer");
            if (i < 4096) begin
                mem[i] = 16'(i) * 16'h9E37 ^ 16'h5A5A;
                bus_req <= '{req: 1'b1, we: 1'b1, fetch: 1'b0, addr: wa(12'(i)) | 24'h000001, wdata: mem[i]};
            end else begin
                bus_req.req <= 1'b0;
            end
        end
    endtask : fill_all
    task automatic t_bus;
        bus_op(1'b0, 1'b0, wa(12'h000), 16'h0000, 1'b1, 1'b0);
        bus_op(1'b0, 1'b0, wa(12'hFFF), 16'h0000, 1'b1, 1'b0);
        bus_op(1'b1, 1'b0, wa(12'h005), 16'hBEEF, 1'b1, 1'b0);
        bus_op(1'b0, 1'b0, wa(12'h005) | 24'h000001, 16'h0000, 1'b1, 1'b0);
        bus_op(1'b0, 1'b1, wa(12'h006), 16'h0000, 1'b1, 1'b1);
        bus_op(1'b1, 1'b0, 24'hFFC00A, 16'h1234, 1'b0, 1'b0);
    endtask : t_bus
    // Write then read of one word in back-to-back cycles
    task automatic t_b2b;
        @(negedge ref_clk);
        bus_req <= '{req: 1'b1, we: 1'b1, fetch: 1'b0, addr: wa(12'h00A), wdata: 16'hC3A5};
        mem[12'h00A] = 16'hC3A5;
        @(negedge ref_clk);
        bus_req <= '{req: 1'b1, we: 1'b0, fetch: 1'b0, addr: wa(12'h00A), wdata: 16'h0000};
        check({bus_ack_q, bus_err_q}, 2'b10, "b2b write answer");
        @(negedge ref_clk);
        bus_req.req <= 1'b0;
        last_rd = 16'hC3A5;
        check({bus_ack_q, bus_err_q}, 2'b10, "b2b read answer");
        check(bus_rdata, last_rd, "b2b read data");
    endtask : t_b2b
    // Bus refused during emulation, both coprocessors read together
    task automatic t_emu;
        run_b <= 1'b1;
        repeat (3) @(negedge ref_clk);
        bus_op(1'b1, 1'b0, wa(12'h005), 16'hDEAD, 1'b1, 1'b1);
        bus_op(1'b0, 1'b0, wa(12'h007), 16'h0000, 1'b1, 1'b1);
        run_a <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            @(negedge ref_clk);
            hold_b <= k[1];
        end
        run_a <= 1'b0;
        run_b <= 1'b0;
        hold_b <= 1'b0;
        repeat (3) @(negedge ref_clk);
        bus_op(1'b0, 1'b0, wa(12'h005), 16'h0000, 1'b1, 1'b0);
    endtask : t_emu
    task automatic t_stop;
        @(negedge ref_clk);
        stop_req <= 1'b1;
        @(negedge ref_clk);
        check(low_power_q, 1'b1, "stop entered");
        bus_op(1'b1, 1'b0, wa(12'h001), 16'h0F0F, 1'b1, 1'b1);
        stop_req <= 1'b0;
        run_b <= 1'b1;
        repeat (3) @(negedge ref_clk);
        stop_req <= 1'b1;
        repeat (4) begin
            @(negedge ref_clk);
            check(low_power_q, 1'b0, "stop held off");
        end
        run_b <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check(low_power_q, 1'b1, "stop after emulation");
        stop_req <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check(low_power_q, 1'b0, "stop left");
    endtask : t_stop
    // Full signature walk, second start while busy is ignored
    task automatic t_sig;
        logic [SIG_W-1:0] sig;
        int k;
        sig = SIG_SEED;
        for (int w = 0; w < 4096; w++) begin
            sig = {sig[SIG_W-2:0], 1'b0} ^ (sig[SIG_W-1] ? SIG_POLY : 32'h00000000) ^ {16'h0000, mem[w]};
        end
        misc_start <= 1'b1;
        @(negedge ref_clk);
        misc_start <= 1'b0;
        @(negedge ref_clk);
        check(misc_busy_q, 1'b1, "walk busy");
        misc_start <= 1'b1;
        @(negedge ref_clk);
        misc_start <= 1'b0;
        k = 0;
        while (misc_done_q !== 1'b1 && k < 9000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 9000) begin
            check(1'b0, 1'b1, "walk timeout");
        end
        @(negedge ref_clk);
        check({misc_done_q, misc_busy_q}, 2'b00, "walk finished");
        check(misc_sig_q, sig, "signature");
    endtask : t_sig
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(negedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        t_reset();
        fill_all();
        t_bus();
        t_b2b();
        t_emu();
        t_stop();
        t_sig();
        print_verdict();
    end
endmodule : dual_port_coproc_ram_tb
